// [design/rph_consts.vh]
// Purpose: constants for the radio packet handler and sequencer block
// Assumes: 8-bit register port, byte addresses as printed
// Notes: included by rph_top.v
`ifndef RPH_CONSTS_VH
`define RPH_CONSTS_VH
// register addresses
`define RPH_A_LEADIN_HI   8'h25
`define RPH_A_LEADIN_LO   8'h26
`define RPH_A_FMT         8'h30
`define RPH_A_MODE        8'h31
`define RPH_A_LEN_LO      8'h32
`define RPH_A_OWN_ID      8'h33
`define RPH_A_ALL_ID      8'h34
`define RPH_A_THRESH      8'h35
`define RPH_A_SEQ1        8'h36
`define RPH_A_SEQ2        8'h37
`define RPH_A_STATUS      8'h38
// reset values
`define RPH_RST_FMT       8'h90
`define RPH_RST_MODE      8'h40
`define RPH_RST_LEN_LO    8'h40
`define RPH_RST_ID        8'h00
`define RPH_RST_THRESH    8'h8f
`define RPH_RST_SEQ1      8'h00
`define RPH_RST_SEQ2      8'h00
`define RPH_RST_LEADIN    16'h0003
// field positions
`define RPH_F_LENKIND     7
`define RPH_F_CODING_HI   6
`define RPH_F_CODING_LO   5
`define RPH_F_CHKEN       4
`define RPH_F_KEEPBUF     3
`define RPH_F_FILT_HI     2
`define RPH_F_FILT_LO     1
`define RPH_F_VARIANT     0
`define RPH_F_PKTMODE     6
`define RPH_F_REPEAT      3
`define RPH_F_LEN_HI      2
`define RPH_F_TRIG        7
`define RPH_F_MARK_HI     5
`define RPH_F_LAUNCH      7
`define RPH_F_HALT        6
`define RPH_F_PAUSEPWR    5
`define RPH_F_LT_HI       4
`define RPH_F_LT_LO       3
`define RPH_F_QUIET       2
`define RPH_F_PAUSEX      1
`define RPH_F_SENDX       0
`define RPH_F_LX_HI       7
`define RPH_F_LX_LO       5
// codes
`define RPH_FILT_OWN      2'h1
`define RPH_FILT_ALL      2'h2
`define RPH_LT_QUIET      2'h0
`define RPH_LT_RX         2'h1
`define RPH_LT_TX         2'h2
`define RPH_LX_READY_PR   3'h1
`define RPH_LX_READY_LP   3'h2
`define RPH_LX_CHK_PR     3'h3
`define RPH_MODE_SLEEP    2'h0
`define RPH_MODE_STBY     2'h1
`define RPH_MODE_TX       2'h2
`define RPH_MODE_RX       2'h3
`define RPH_ZERO8         8'h00
`define RPH_ONE8          8'h01
`endif

// [design/rph_top.v]
// Purpose: packet handler settings and top-level sequencer of a radio
// Assumes: buffer, modem and timers outside give counts and events
// Notes: all outputs are registered; reads answer one cycle later
//
// Operation
// R1: frame_length_kind 0 fixed, 1 variable; resets to variable.
// R2: line_balance_coding none, Manchester, whitening, reserved; resets to none.
// R3: checksum_enable appends on transmit and checks on receive; resets on.
// R4: bad check flushes and restarts unless keep bit, which raises ready.
// R5: address filter off, own id, own or all ids; eight-bit ids.
// R6: variant selects CCITT/standard whitening or IBM/alternate whitening.
// R7: framing_vs_raw_select 0 continuous, 1 packet mode; resets packet.
// R8: repeat_frame_enable gives beacon, only in fixed-length framing.
// R9: eleven-bit body count; fixed length, or variable receive maximum.
// R10: send trigger on fill level, or when buffer is not empty.
// R11: fill flag when buffer count at least mark plus one; mark resets 15.
// R12: launch honoured only from Sleep or Standby chip mode.
// R13: halt forces sequencer off at once; reads back zero.
// R14: idle state holds Standby or Sleep per pause_power_select.
// R15: launch_target picks low-power, receive, transmit, or transmit on fill.
// R16: low-power selection goes off with initial mode, or to idle.
// R17: idle exits on timer one event to transmit or receive.
// R18: transmit exits on frame sent to low-power selection or receive.
// R19: lead-in length is sixteen bits, resets to three.
// R20: listen_exit_target picks receive-state exit event and destination.
// R21: launch self-clears after the start transition; reads zero.
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "rph_consts.vh"
module rph_top
(
  input wire core_clk_i,
  input wire rst_n_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] buf_count_i,
  input wire timer_one_event_i,
  input wire frame_sent_i,
  input wire rx_frame_done_i,
  input wire rx_check_ok_i,
  input wire [7:0] rx_addr_byte_i,
  input wire rx_addr_valid_i,
  input wire [1:0] chip_mode_i,
  input wire rx_other_event_i,
  output reg [7:0] reg_rdata_o,
  output reg buffer_fill_flag_o,
  output reg send_start_o,
  output reg body_received_flag_o,
  output reg check_pass_flag_o,
  output reg buffer_flush_o,
  output reg rx_restart_o,
  output reg addr_drop_o,
  output reg [1:0] mode_req_o,
  output reg mode_req_valid_o,
  output reg [4:0] seq_state_o
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg rst_meta_q;
  reg rst_sync_q;
  // two stages so release never lands near an edge
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire rst_n = rst_sync_q;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] fmt_q;
  reg [7:0] mode_q;
  reg [7:0] len_lo_q;
  reg [7:0] own_id_q;
  reg [7:0] all_id_q;
  reg [7:0] thresh_q;
  reg [7:0] seq1_q;
  reg [7:0] seq2_q;
  reg [15:0] leadin_q;
  reg launch_q;
  reg halt_q;
  wire wr_fmt = reg_wr_i && (reg_addr_i == `RPH_A_FMT);
  wire wr_seq1 = reg_wr_i && (reg_addr_i == `RPH_A_SEQ1);

  // software writes; trigger bits are held apart as one-cycle strobes
  always @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fmt_q <= `RPH_RST_FMT; // [R1] [R2] [R3]
      mode_q <= `RPH_RST_MODE; // [R7]
      len_lo_q <= `RPH_RST_LEN_LO;
      own_id_q <= `RPH_RST_ID;
      all_id_q <= `RPH_RST_ID;
      thresh_q <= `RPH_RST_THRESH; // [R10] [R11]
      seq1_q <= `RPH_RST_SEQ1;
      seq2_q <= `RPH_RST_SEQ2;
      leadin_q <= `RPH_RST_LEADIN; // [R19]
      launch_q <= 1'b0;
      halt_q <= 1'b0;
    end
    else
    begin
      launch_q <= wr_seq1 && reg_wdata_i[`RPH_F_LAUNCH]; // [R21]
      halt_q <= wr_seq1 && reg_wdata_i[`RPH_F_HALT]; // [R13]
      if (wr_fmt)
        fmt_q <= reg_wdata_i;
      if (reg_wr_i)
      begin
        case (reg_addr_i)
          `RPH_A_MODE: mode_q <= {1'b0, reg_wdata_i[6:0]};
          `RPH_A_LEN_LO: len_lo_q <= reg_wdata_i;
          `RPH_A_OWN_ID: own_id_q <= reg_wdata_i;
          `RPH_A_ALL_ID: all_id_q <= reg_wdata_i;
          `RPH_A_THRESH: thresh_q <= {reg_wdata_i[7], 1'b0,
                                      reg_wdata_i[5:0]};
          `RPH_A_SEQ1: seq1_q <= {2'b00, reg_wdata_i[5:0]};
          `RPH_A_SEQ2: seq2_q <= reg_wdata_i;
          `RPH_A_LEADIN_HI: leadin_q[15:8] <= reg_wdata_i;
          `RPH_A_LEADIN_LO: leadin_q[7:0] <= reg_wdata_i;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire fixed_len = !fmt_q[`RPH_F_LENKIND]; // [R1]
  wire [1:0] coding = fmt_q[`RPH_F_CODING_HI:`RPH_F_CODING_LO]; // [R2]
  wire chk_en = fmt_q[`RPH_F_CHKEN]; // [R3]
  wire keep_buf = fmt_q[`RPH_F_KEEPBUF];
  wire [1:0] filt = fmt_q[`RPH_F_FILT_HI:`RPH_F_FILT_LO];
  wire variant = fmt_q[`RPH_F_VARIANT]; // [R6]
  wire pkt_mode = mode_q[`RPH_F_PKTMODE]; // [R7]
  // beacon only honoured with fixed framing
  wire beacon = mode_q[`RPH_F_REPEAT] && fixed_len; // [R8]
  wire [10:0] body_count = {mode_q[`RPH_F_LEN_HI:0], len_lo_q}; // [R9]
  wire [7:0] mark_p1 = {2'b00, thresh_q[`RPH_F_MARK_HI:0]} + `RPH_ONE8;
  wire [1:0] launch_tgt = seq1_q[`RPH_F_LT_HI:`RPH_F_LT_LO];
  wire [2:0] listen_x = seq2_q[`RPH_F_LX_HI:`RPH_F_LX_LO];
  wire fill_now = (buf_count_i >= mark_p1); // [R11]
  // not-empty start avoids waiting on a mark the frame never reaches
  wire trig_now = thresh_q[`RPH_F_TRIG] ?
                  (buf_count_i != `RPH_ZERO8) : fill_now; // [R10]

  // ----------------------------------------------------------------
  // receive filtering and checking
  // ----------------------------------------------------------------
  wire own_hit = (rx_addr_byte_i == own_id_q);
  wire all_hit = (rx_addr_byte_i == all_id_q);
  reg addr_ok;
  // reserved code passes frames unfiltered
  always @*
  begin
    case (filt)
      `RPH_FILT_OWN: addr_ok = own_hit; // [R5]
      `RPH_FILT_ALL: addr_ok = own_hit || all_hit; // [R5]
      default: addr_ok = 1'b1;
    endcase
  end
  wire rx_pkt = pkt_mode && rx_frame_done_i;
  wire chk_bad = chk_en && !rx_check_ok_i; // [R3]
  wire ready_ev = rx_pkt && (!chk_bad || keep_buf); // [R4]
  wire chk_ev = rx_pkt && !chk_bad;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  localparam S_OFF = 5'h01;
  localparam S_IDLE = 5'h02;
  localparam S_TX = 5'h04;
  localparam S_RX = 5'h08;
  localparam S_TXWAIT = 5'h10;
  reg [4:0] st_q;
  reg [4:0] st_d;
  reg [1:0] init_mode_q;
  reg [1:0] mode_d;
  wire low_ok = (chip_mode_i == `RPH_MODE_SLEEP) ||
                (chip_mode_i == `RPH_MODE_STBY);
  wire go = launch_q && low_ok && (st_q == S_OFF); // [R12]
  // quiet landing: off restores the initial mode, idle holds low power
  wire [4:0] quiet_st = seq1_q[`RPH_F_QUIET] ? S_IDLE : S_OFF; // [R16]
  wire [1:0] idle_mode = seq1_q[`RPH_F_PAUSEPWR] ?
                         `RPH_MODE_SLEEP : `RPH_MODE_STBY; // [R14]
  reg rx_exit;
  reg [4:0] rx_dest;
  always @*
  begin
    case (listen_x)
      `RPH_LX_READY_PR: rx_exit = ready_ev; // [R20]
      `RPH_LX_READY_LP: rx_exit = ready_ev;
      `RPH_LX_CHK_PR: rx_exit = chk_ev;
      default: rx_exit = rx_other_event_i;
    endcase
    rx_dest = (listen_x == `RPH_LX_READY_LP) ? quiet_st : S_OFF;
  end

  // next state; halt overrides everything
  always @*
  begin
    st_d = st_q;
    case (st_q)
      S_OFF:
        if (go)
        begin
          case (launch_tgt)
            `RPH_LT_QUIET: st_d = quiet_st; // [R15]
            `RPH_LT_RX: st_d = S_RX;
            `RPH_LT_TX: st_d = S_TX;
            default: st_d = S_TXWAIT;
          endcase
        end
      S_TXWAIT:
        if (fill_now)
          st_d = S_TX; // [R15]
      S_IDLE:
        if (timer_one_event_i)
          st_d = seq1_q[`RPH_F_PAUSEX] ? S_RX : S_TX; // [R17]
      S_TX:
        if (frame_sent_i)
          st_d = seq1_q[`RPH_F_SENDX] ? S_RX : quiet_st; // [R18]
      S_RX:
        if (rx_exit)
          st_d = rx_dest; // [R20]
      default: st_d = S_OFF;
    endcase
    if (halt_q)
      st_d = S_OFF; // [R13]
  end

  // requested chip mode per state
  always @*
  begin
    case (st_d)
      S_IDLE: mode_d = idle_mode; // [R14]
      S_TX: mode_d = `RPH_MODE_TX;
      S_RX: mode_d = `RPH_MODE_RX;
      S_TXWAIT: mode_d = `RPH_MODE_TX;
      default: mode_d = init_mode_q; // [R16]
    endcase
  end

  // ----------------------------------------------------------------
  // state, outputs and read data
  // ----------------------------------------------------------------
  reg [7:0] rd_d;
  always @*
  begin
    case (reg_addr_i)
      `RPH_A_FMT: rd_d = fmt_q;
      `RPH_A_MODE: rd_d = mode_q;
      `RPH_A_LEN_LO: rd_d = len_lo_q;
      `RPH_A_OWN_ID: rd_d = own_id_q;
      `RPH_A_ALL_ID: rd_d = all_id_q;
      `RPH_A_THRESH: rd_d = thresh_q;
      `RPH_A_SEQ1: rd_d = seq1_q; // [R13] [R21]
      `RPH_A_SEQ2: rd_d = seq2_q;
      `RPH_A_LEADIN_HI: rd_d = leadin_q[15:8];
      `RPH_A_LEADIN_LO: rd_d = leadin_q[7:0];
      `RPH_A_STATUS: rd_d = {beacon, coding, variant, st_q[3:0]};
      default: rd_d = `RPH_ZERO8;
    endcase
  end

  always @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= S_OFF;
      init_mode_q <= `RPH_MODE_STBY;
      reg_rdata_o <= `RPH_ZERO8;
      buffer_fill_flag_o <= 1'b0;
      send_start_o <= 1'b0;
      body_received_flag_o <= 1'b0;
      check_pass_flag_o <= 1'b0;
      buffer_flush_o <= 1'b0;
      rx_restart_o <= 1'b0;
      addr_drop_o <= 1'b0;
      mode_req_o <= `RPH_MODE_STBY;
      mode_req_valid_o <= 1'b0;
      seq_state_o <= S_OFF;
    end
    else
    begin
      st_q <= st_d;
      if (go)
        init_mode_q <= chip_mode_i; // [R16]
      reg_rdata_o <= reg_rd_i ? rd_d : `RPH_ZERO8;
      buffer_fill_flag_o <= fill_now; // [R11]
      send_start_o <= pkt_mode && trig_now; // [R10]
      body_received_flag_o <= ready_ev; // [R4]
      check_pass_flag_o <= chk_ev;
      // bad check without keep: flush and listen for a new frame
      buffer_flush_o <= rx_pkt && chk_bad && !keep_buf; // [R4]
      rx_restart_o <= rx_pkt && chk_bad && !keep_buf; // [R4]
      addr_drop_o <= pkt_mode && rx_addr_valid_i && !addr_ok; // [R5]
      mode_req_o <= mode_d;
      mode_req_valid_o <= (st_d != st_q);
      seq_state_o <= st_d;
    end
  end
endmodule // rph_top
`default_nettype wire

// [sim/rph_chk.sv]
// Purpose: assertion checker for rph_top
// Assumes: shadow copies follow register writes
// Notes: bound to rph_top at the foot
`timescale 1ns/10ps
`default_nettype none
module rph_chk
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] buf_count_i,
  input wire logic timer_one_event_i,
  input wire logic frame_sent_i,
  input wire logic rx_frame_done_i,
  input wire logic rx_check_ok_i,
  input wire logic rx_addr_valid_i,
  input wire logic [1:0] chip_mode_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic buffer_fill_flag_o,
  input wire logic body_received_flag_o,
  input wire logic buffer_flush_o,
  input wire logic rx_restart_o,
  input wire logic addr_drop_o,
  input wire logic [4:0] seq_state_o
);
  logic [7:0] fmt_q;
  logic [7:0] seq_q;
  logic [5:0] mark_q;
  logic pkt_q;
  logic wr_seq;
  logic bad;
  assign wr_seq = reg_wr_i && reg_addr_i == 8'h36;
  // continuous mode bypasses the packet handler, so no check result counts
  assign bad = rx_frame_done_i && !rx_check_ok_i && fmt_q[4] && pkt_q;
  // settings shadow, so checks need no view inside
  always_ff @(posedge core_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      fmt_q <= 8'h90;
      seq_q <= 8'h00;
      mark_q <= 6'h0f;
      pkt_q <= 1'b1;
    end
    else if (reg_wr_i && reg_addr_i == 8'h30)
      fmt_q <= reg_wdata_i;
    else if (wr_seq)
      seq_q <= reg_wdata_i;
    else if (reg_wr_i && reg_addr_i == 8'h35)
      mark_q <= reg_wdata_i[5:0];
    else if (reg_wr_i && reg_addr_i == 8'h31)
      pkt_q <= reg_wdata_i[6];
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_unmapped_read_zero: assert property (reg_rd_i && !(reg_addr_i inside
    {8'h25, 8'h26, [8'h30:8'h38]}) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read gave data");
  a_fill_level: assert property (##1 buffer_fill_flag_o ==
    ($past(buf_count_i) >= $past(mark_q) + 8'd1))
    else $error("fill flag wrong");
  a_halt_off: assert property (wr_seq && reg_wdata_i[6] |->
    ##[1:3] seq_state_o == 5'h01) else $error("halt ignored");
  a_launch_rx: assert property (wr_seq && reg_wdata_i[7:6] == 2'b10 &&
    reg_wdata_i[4:3] == 2'b01 && seq_state_o == 5'h01 ##1
    chip_mode_i < 2'd2 |-> ##[0:2] seq_state_o == 5'h08)
    else $error("launch to receive failed");
  a_launch_refused: assert property (wr_seq && reg_wdata_i[7] &&
    seq_state_o == 5'h01 ##1 chip_mode_i == 2'd2 |=>
    seq_state_o == 5'h01 [*3]) else $error("launch from transmit");
  a_idle_exit: assert property (seq_state_o == 5'h02 &&
    timer_one_event_i && !wr_seq |-> ##[1:2]
    seq_state_o == (seq_q[1] ? 5'h08 : 5'h04)) else $error("idle exit");
  a_send_exit: assert property (seq_state_o == 5'h04 &&
    frame_sent_i && seq_q[0] && !wr_seq |-> ##[1:2] seq_state_o == 5'h08)
    else $error("transmit exit wrong");
  a_bad_flush: assert property (bad && !fmt_q[3] |=>
    buffer_flush_o && rx_restart_o && !body_received_flag_o)
    else $error("bad check not flushed");
  a_bad_keep: assert property (bad && fmt_q[3] |=>
    body_received_flag_o && !buffer_flush_o) else $error("bad check kept");
  a_drop_cause: assert property (addr_drop_o |->
    $past(rx_addr_valid_i) && $past(fmt_q[2:1]) != 2'b00)
    else $error("drop without filter");
  c_idle_rx: cover property (seq_state_o == 5'h02 ##[1:2] seq_state_o == 5'h08);
  c_flush: cover property (buffer_flush_o);
  c_drop: cover property (addr_drop_o);
endmodule // rph_chk
bind rph_top rph_chk u_chk (.*);
`default_nettype wire

// [sim/rph_far_model.sv]
// Purpose: chip mode and remote link stand-in for rph_top
// Assumes: chip mode follows every valid mode request, except while force_tx_i pins transmit
// Notes: frame sent after 3 or 21 cycles in transmit
`timescale 1ns/10ps
`default_nettype none
module rph_far_model
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] mode_req_i,
  input wire logic mode_valid_i,
  input wire logic force_tx_i,
  input wire logic slow_i,
  output logic [1:0] chip_mode_o,
  output logic frame_sent_o
);
  logic [1:0] mode_q;
  logic [4:0] cnt_q;
  // force lets the bench pin transmit mode for a refused launch
  assign chip_mode_o = force_tx_i ? 2'd2 : mode_q;
  // count time in transmit; the link reports the frame gone when the count hits the mark, and again every 32 cycles
  always_ff @(posedge core_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      mode_q <= 2'd1;
      cnt_q <= 5'd0;
      frame_sent_o <= 1'b0;
    end
    else
    begin
      if (mode_valid_i)
        mode_q <= mode_req_i;
      cnt_q <= (mode_q == 2'd2) ? cnt_q + 5'd1 : 5'd0;
      frame_sent_o <= mode_q == 2'd2 && cnt_q == (slow_i ? 5'd20 : 5'd2);
    end
endmodule // rph_far_model
`default_nettype wire

// [sim/rph_top_tb.sv]
// Purpose: self-checking bench for rph_top
// Assumes: register reads answer one cycle after the strobe
// Notes: far model drives chip mode and frame sent
`timescale 1ns/10ps
`default_nettype none
module rph_top_tb;
  logic core_clk_i, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, buf_count_i = 0;
  logic [7:0] rx_addr_byte_i = 0, reg_rdata_o;
  logic timer_one_event_i = 0, rx_frame_done_i = 0, rx_check_ok_i = 0;
  logic rx_addr_valid_i = 0, rx_other_event_i = 0, frame_sent_i;
  logic force_tx = 0, slow = 0, mode_req_valid_o, send_start_o;
  logic buffer_fill_flag_o, body_received_flag_o, check_pass_flag_o;
  logic buffer_flush_o, rx_restart_o, addr_drop_o;
  logic [1:0] chip_mode_i, mode_req_o;
  logic [4:0] seq_state_o;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  rph_top DUT (.*);
  rph_far_model u_far (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .mode_req_i(mode_req_o), .mode_valid_i(mode_req_valid_o),
    .force_tx_i(force_tx), .slow_i(slow), .chip_mode_o(chip_mode_i),
    .frame_sent_o(frame_sent_i));
  initial
  begin
    core_clk_i = 0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // a hung wait ends the run as a failure
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1;
    @(posedge core_clk_i);
    reg_wr_i <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1;
    @(posedge core_clk_i);
    reg_rd_i <= 0;
    #1 chk(reg_rdata_o, exp);
  endtask
  task automatic settle;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask
  // reset values, unmapped read, read-zero bits
  task automatic t_regs;
    logic [7:0] ra[10] = '{8'h25, 8'h26, 8'h30, 8'h31, 8'h32, 8'h33,
      8'h34, 8'h35, 8'h36, 8'h50};
    logic [7:0] rv[10] = '{8'h00, 8'h03, 8'h90, 8'h40, 8'h40, 8'h00,
      8'h00, 8'h8f, 8'h00, 8'h00};
    foreach (ra[i])
      rd(ra[i], rv[i]);
    wr(8'h36, 8'he7);
    rd(8'h36, 8'h27);
    chk(seq_state_o, 8'h01);
    wr(8'h31, 8'hcf);
    rd(8'h31, 8'h4f);
    // beacon shows in status only while fixed framing is chosen
    rd(8'h38, 8'h01);
    wr(8'h30, 8'h10);
    rd(8'h38, 8'h81);
    wr(8'h30, 8'h90);
  endtask
  task automatic setbuf(input logic [7:0] v, input logic f, input logic s);
    @(posedge core_clk_i);
    buf_count_i <= v;
    settle();
    chk(buffer_fill_flag_o, f);
    chk(send_start_o, s);
  endtask
  // fill mark boundary and both send triggers
  task automatic t_fill;
    wr(8'h35, 8'h04);
    setbuf(8'h04, 0, 0);
    setbuf(8'h05, 1, 1);
    wr(8'h35, 8'h84);
    setbuf(8'h01, 0, 1);
    setbuf(8'h00, 0, 0);
  endtask
  // launch to transmit, idle after frame sent, timer exit
  task automatic t_seq(input logic [7:0] cfg, input logic sl,
    input logic [1:0] md, input logic [4:0] nxt);
    slow <= sl;
    wr(8'h36, cfg);
    for (int i = 0; i < 60 && seq_state_o !== 5'h02; i++)
      @(posedge core_clk_i);
    #1 chk(seq_state_o, 8'h02);
    chk(mode_req_o, md);
    @(posedge core_clk_i);
    timer_one_event_i <= 1;
    @(posedge core_clk_i);
    timer_one_event_i <= 0;
    settle();
    chk(seq_state_o, nxt);
    wr(8'h36, 8'h40);
    settle();
    chk(seq_state_o, 8'h01);
  endtask
  // launch to receive, then refused launch in transmit mode
  task automatic t_launch;
    wr(8'h36, 8'h88);
    settle();
    chk(seq_state_o, 8'h08);
    chk(mode_req_o, 8'h03);
    wr(8'h36, 8'h40);
    force_tx <= 1;
    wr(8'h36, 8'h88);
    settle();
    chk(seq_state_o, 8'h01);
    force_tx <= 0;
  endtask
  // launch waits on fill, transmit exits to receive, receive exits off
  task automatic t_send_rx;
    slow <= 1;
    wr(8'h36, 8'h99);
    settle();
    chk(seq_state_o, 8'h10);
    wr(8'h37, 8'h20);
    buf_count_i <= 8'h05;
    for (int i = 0; i < 60 && seq_state_o !== 5'h08; i++)
      @(posedge core_clk_i);
    #1 chk(seq_state_o, 8'h08);
    @(posedge core_clk_i);
    buf_count_i <= 8'h00;
    rx_frame_done_i <= 1;
    rx_check_ok_i <= 1;
    @(posedge core_clk_i);
    rx_frame_done_i <= 0;
    settle();
    chk(seq_state_o, 8'h01);
  endtask
  // every filter code against own, all-stations and foreign ids
  task automatic t_filter;
    logic [3:0] dx[3] = '{4'b0010, 4'b0000, 4'b0110};
    logic [7:0] ab[3] = '{8'ha5, 8'h5a, 8'h33};
    wr(8'h33, 8'h5a);
    wr(8'h34, 8'ha5);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h30, 8'h90 | (c << 1));
      for (int k = 0; k < 3; k++)
      begin
        @(posedge core_clk_i);
        rx_addr_byte_i <= ab[k];
        rx_addr_valid_i <= 1;
        @(posedge core_clk_i);
        rx_addr_valid_i <= 0;
        #1 chk(addr_drop_o, dx[k][c]);
      end
    end
  endtask
  // checksum fail with flush, pass, fail kept, checksum off
  task automatic t_check;
    logic [7:0] fm[4] = '{8'h90, 8'h90, 8'h98, 8'h80};
    logic [3:0] ok = 4'b0010, bd = 4'b1110, fl = 4'b0001, ps = 4'b1010;
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h30, fm[i]);
      @(posedge core_clk_i);
      rx_frame_done_i <= 1;
      rx_check_ok_i <= ok[i];
      @(posedge core_clk_i);
      rx_frame_done_i <= 0;
      #1 chk(body_received_flag_o, bd[i]);
      chk(buffer_flush_o, fl[i]);
      chk(rx_restart_o, fl[i]);
      chk(check_pass_flag_o, ps[i]);
    end
  endtask
  initial
  begin
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1;
    repeat (3) @(posedge core_clk_i);
    t_regs();
    t_fill();
    t_launch();
    t_seq(8'h96, 0, 2'h1, 5'h08);
    t_seq(8'hb4, 1, 2'h0, 5'h04);
    t_send_rx();
    t_filter();
    t_check();
    summarize();
  end
endmodule // rph_top_tb
`default_nettype wire
